// >>> design/awc_pkg.sv
/*
 * Constants for the converter window and input configuration block.
 * Assumes a single system clock and the special-function-register port of the core.
 */
package awc_pkg;

    // ****************************************
    // Register map, page and offsets
    // ****************************************
    localparam logic [7:0] AWC_PAGE = 8'h00;
    localparam logic [7:0] AWC_OFF_PAIR_CFG = 8'hba;
    localparam logic [7:0] AWC_OFF_UPPER_LO = 8'hc4;
    localparam logic [7:0] AWC_OFF_UPPER_HI = 8'hc5;
    localparam logic [7:0] AWC_OFF_LOWER_LO = 8'hc6;
    localparam logic [7:0] AWC_OFF_LOWER_HI = 8'hc7;
    localparam logic [7:0] AWC_OFF_CTRL = 8'he8;
    localparam logic [7:0] AWC_OFF_CONFIG = 8'hbc;
    localparam logic [7:0] AWC_OFF_PORT_SEL = 8'hbd;

    // ****************************************
    // Values after reset
    // ****************************************
    localparam logic [7:0] AWC_RST_PAIR_CFG = 8'h00;
    localparam logic [7:0] AWC_RST_UPPER_LO = 8'hff;
    localparam logic [7:0] AWC_RST_UPPER_HI = 8'hff;
    localparam logic [7:0] AWC_RST_LOWER_LO = 8'h00;
    localparam logic [7:0] AWC_RST_LOWER_HI = 8'h00;
    localparam logic [7:0] AWC_RST_CTRL = 8'h00;
    localparam logic [7:0] AWC_RST_CONFIG = 8'hf8;
    localparam logic [7:0] AWC_RST_PORT_SEL = 8'h00;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int AWC_CTRL_EN_BIT = 7;
    localparam int AWC_CTRL_BUSY_BIT = 4;
    localparam int AWC_CTRL_FLAG_BIT = 1;
    localparam int AWC_CTRL_LJUST_BIT = 0;
    localparam int AWC_CFG_DIV_LSB = 3;
    localparam int AWC_CFG_GAIN_LSB = 0;
    localparam logic [2:0] AWC_GAIN_UNITY = 3'h0;
    localparam logic [3:0] AWC_PAIR_MASK = 4'hf;

    // ****************************************
    // Timing
    // ****************************************
    localparam logic [4:0] AWC_SAR_CLKS_PER_CONV = 5'h10;
    localparam int AWC_CODE_W = 12;

    typedef enum logic [0:0] {
        AWC_ST_IDLE = 1'b0,
        AWC_ST_CONV = 1'b1
    } awc_state_t;

endpackage

// >>> design/awc_win_if.sv
/*
 * Carrier between the register/sequencer top and the window comparator.
 * Assumes both ends sit on the same system clock.
 */
`timescale 1ns/1ps
interface awc_win_if;
    logic done;
    logic [11:0] raw_code;
    logic is_diff;
    logic left_just;
    logic [15:0] upper;
    logic [15:0] lower;
    logic res_valid;
    logic [15:0] result;
    logic match;

    modport ctl (output done, raw_code, is_diff, left_just, upper, lower,
                 input res_valid, result, match);
    modport cmp (input done, raw_code, is_diff, left_just, upper, lower,
                 output res_valid, result, match);
endinterface

// >>> design/awc_window.sv
/*
 * Result formatter and window comparator, evaluated once per completed conversion.
 * Assumes done is a one-cycle pulse with raw_code stable in that cycle.
 */
`timescale 1ns/1ps
module awc_window
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    awc_win_if.cmp win
);
    import awc_pkg::*;

    logic [15:0] fmt_d;
    logic below_d;
    logic above_d;
    logic match_d;

    // Signed when the channel is a differential pair, else unsigned
    function automatic logic less_than(input logic [15:0] a, input logic [15:0] b, input logic sgn);
        if (sgn)
            less_than = $signed(a) < $signed(b);
        else
            less_than = a < b;
    endfunction

    always_comb
    begin
        if (win.left_just)
            fmt_d = {win.raw_code, 4'h0};
        else if (win.is_diff)
            fmt_d = {{4{win.raw_code[AWC_CODE_W-1]}}, win.raw_code};
        else
            fmt_d = {4'h0, win.raw_code};
        below_d = less_than(fmt_d, win.lower, win.is_diff);
        above_d = less_than(win.upper, fmt_d, win.is_diff);
        // Limit order picks inside or outside the window
        if (less_than(win.upper, win.lower, win.is_diff))
            match_d = below_d && above_d;
        else
            match_d = below_d || above_d;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            win.res_valid <= 1'b0;
            win.result <= 16'h0000;
            win.match <= 1'b0;
        end
        else
        begin
            win.res_valid <= win.done;
            win.match <= win.done && match_d;
            if (win.done)
                win.result <= fmt_d;
        end
    end

    match_on_done_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        win.match |-> $past(win.done)) else $error("match without a conversion");
    inside_window_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (win.done && !win.is_diff && !win.left_just && win.upper < win.lower
         && {4'h0, win.raw_code} > win.upper && {4'h0, win.raw_code} < win.lower) |=> win.match)
        else $error("inside-window result not flagged");
    outside_window_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (win.done && !win.is_diff && !win.left_just && win.upper >= win.lower
         && {4'h0, win.raw_code} > win.upper) |=> win.match)
        else $error("outside-window result not flagged");
    diff_sign_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (win.done && win.is_diff && !win.left_just) |=> win.result[15:12] == {4{win.result[11]}})
        else $error("differential result not sign extended");
endmodule

// >>> design/awc_top.sv
/*
 * Converter window detector and input configuration registers with conversion sequencer.
 * Assumes the special-function-register port of the core and a SAR code from the analog
 * converter, both on i_mclk.
 */
// Function
// - Every completed result is compared against both limits automatically.
// - Window match flag is readable and drives an interrupt request output.
// - Upper and lower limits each have separately writable high and low bytes.
// - Limit ordering selects inside-window or outside-window matching.
// - Upper limit low byte resets to all ones, at 0xC4 page 0.
// - Converter, track-hold and gain stage run only while enable is set.
// - All input pairs are single-ended after reset.
// - Three-bit gain field in configuration register selects gain stage gain.
// - Gain field resets to unity gain.
// - Four low pair-config bits make each input pair differential.
// - Differential channel results are two's complement.
// - Any port pins may be selected; even and odd feed separate inputs.
// - High-voltage amplifier output selectable like any other channel.
// - A conversion lasts at least sixteen SAR clocks.
`timescale 1ns/1ps
module awc_top
(
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic [7:0] i_sfr_page,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic i_sfr_rd,
    input wire logic [3:0] i_chan_sel,
    input wire logic i_conv_start,
    input wire logic [11:0] i_sar_code,
    output logic [7:0] o_sfr_rdata,
    output logic o_conv_enable,
    output logic [2:0] o_gain_sel,
    output logic [3:0] o_pair_diff,
    output logic [3:0] o_even_pin_sel,
    output logic [3:0] o_odd_pin_sel,
    output logic o_sar_clk,
    output logic o_busy,
    output logic o_result_valid,
    output logic [15:0] o_result,
    output logic o_window_irq
);
    import awc_pkg::*;

    awc_win_if win ();

    logic [7:0] pair_cfg_q;
    logic [7:0] upper_lo_q;
    logic [7:0] upper_hi_q;
    logic [7:0] lower_lo_q;
    logic [7:0] lower_hi_q;
    logic [7:0] config_q;
    logic [7:0] port_sel_q;
    logic enable_q;
    logic ljust_q;
    logic flag_q;
    awc_state_t state_q;
    logic [4:0] div_cnt_q;
    logic [4:0] tick_cnt_q;
    logic sar_tick;
    logic done_q;
    logic [11:0] code_q;
    logic diff_q;
    logic [7:0] rdata_d;

    function automatic logic hit(input logic [7:0] off);
        hit = (i_sfr_page == AWC_PAGE) && (i_sfr_addr == off);
    endfunction

    // Which pair bit governs the selected channel; 5 and the sensor are never paired
    function automatic logic chan_is_diff(input logic [3:0] ch, input logic [7:0] cfg);
        case (ch)
            4'h0, 4'h1: chan_is_diff = cfg[0];
            4'h2, 4'h3: chan_is_diff = cfg[1];
            4'h4: chan_is_diff = cfg[2];
            4'h6, 4'h7: chan_is_diff = cfg[3];
            default: chan_is_diff = 1'b0;
        endcase
    endfunction

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            pair_cfg_q <= AWC_RST_PAIR_CFG;
        else if (i_sfr_wr && hit(AWC_OFF_PAIR_CFG))
            pair_cfg_q <= i_sfr_wdata & {4'h0, AWC_PAIR_MASK};
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            upper_lo_q <= AWC_RST_UPPER_LO;
            upper_hi_q <= AWC_RST_UPPER_HI;
            lower_lo_q <= AWC_RST_LOWER_LO;
            lower_hi_q <= AWC_RST_LOWER_HI;
        end
        else if (i_sfr_wr)
        begin
            // Bytes load one at a time; a result landing between two writes sees a mixed limit
            if (hit(AWC_OFF_UPPER_LO))
                upper_lo_q <= i_sfr_wdata;
            if (hit(AWC_OFF_UPPER_HI))
                upper_hi_q <= i_sfr_wdata;
            if (hit(AWC_OFF_LOWER_LO))
                lower_lo_q <= i_sfr_wdata;
            if (hit(AWC_OFF_LOWER_HI))
                lower_hi_q <= i_sfr_wdata;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            config_q <= AWC_RST_CONFIG;
        else if (i_sfr_wr && hit(AWC_OFF_CONFIG))
            config_q <= i_sfr_wdata;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            port_sel_q <= AWC_RST_PORT_SEL;
        else if (i_sfr_wr && hit(AWC_OFF_PORT_SEL))
            port_sel_q <= i_sfr_wdata;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            enable_q <= AWC_RST_CTRL[AWC_CTRL_EN_BIT];
            ljust_q <= AWC_RST_CTRL[AWC_CTRL_LJUST_BIT];
        end
        else if (i_sfr_wr && hit(AWC_OFF_CTRL))
        begin
            enable_q <= i_sfr_wdata[AWC_CTRL_EN_BIT];
            ljust_q <= i_sfr_wdata[AWC_CTRL_LJUST_BIT];
        end
    end

    // ****************************************
    // Window match flag
    // ****************************************
    // A new match wins over a software clear in the same cycle
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            flag_q <= AWC_RST_CTRL[AWC_CTRL_FLAG_BIT];
        else if (win.match)
            flag_q <= 1'b1;
        else if (i_sfr_wr && hit(AWC_OFF_CTRL) && !i_sfr_wdata[AWC_CTRL_FLAG_BIT])
            flag_q <= 1'b0;
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    assign sar_tick = (div_cnt_q == config_q[7:AWC_CFG_DIV_LSB]);

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            state_q <= AWC_ST_IDLE;
            div_cnt_q <= 5'h00;
            tick_cnt_q <= 5'h00;
            done_q <= 1'b0;
            code_q <= 12'h000;
            diff_q <= 1'b0;
        end
        else
        begin
            done_q <= 1'b0;
            case (state_q)
                AWC_ST_IDLE:
                begin
                    div_cnt_q <= 5'h00;
                    tick_cnt_q <= 5'h00;
                    if (i_conv_start && enable_q)
                    begin
                        state_q <= AWC_ST_CONV;
                        diff_q <= chan_is_diff(i_chan_sel, pair_cfg_q);
                    end
                end
                AWC_ST_CONV:
                begin
                    // Shutdown aborts a conversion in flight
                    if (!enable_q)
                        state_q <= AWC_ST_IDLE;
                    else if (sar_tick)
                    begin
                        div_cnt_q <= 5'h00;
                        tick_cnt_q <= tick_cnt_q + 5'h01;
                        if (tick_cnt_q == AWC_SAR_CLKS_PER_CONV - 5'h01)
                        begin
                            state_q <= AWC_ST_IDLE;
                            done_q <= 1'b1;
                            code_q <= i_sar_code;
                        end
                    end
                    else
                        div_cnt_q <= div_cnt_q + 5'h01;
                end
                default:
                    state_q <= AWC_ST_IDLE;
            endcase
        end
    end

    assign win.done = done_q;
    assign win.raw_code = code_q;
    assign win.is_diff = diff_q;
    assign win.left_just = ljust_q;
    assign win.upper = {upper_hi_q, upper_lo_q};
    assign win.lower = {lower_hi_q, lower_lo_q};

    awc_window u_window
    (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .win(win)
    );

    // ****************************************
    // Read port and outputs
    // ****************************************
    always_comb
    begin
        rdata_d = 8'h00;
        if (hit(AWC_OFF_PAIR_CFG))
            rdata_d = pair_cfg_q;
        else if (hit(AWC_OFF_UPPER_LO))
            rdata_d = upper_lo_q;
        else if (hit(AWC_OFF_UPPER_HI))
            rdata_d = upper_hi_q;
        else if (hit(AWC_OFF_LOWER_LO))
            rdata_d = lower_lo_q;
        else if (hit(AWC_OFF_LOWER_HI))
            rdata_d = lower_hi_q;
        else if (hit(AWC_OFF_CONFIG))
            rdata_d = config_q;
        else if (hit(AWC_OFF_PORT_SEL))
            rdata_d = port_sel_q;
        else if (hit(AWC_OFF_CTRL))
        begin
            rdata_d[AWC_CTRL_EN_BIT] = enable_q;
            rdata_d[AWC_CTRL_BUSY_BIT] = (state_q == AWC_ST_CONV);
            rdata_d[AWC_CTRL_FLAG_BIT] = flag_q;
            rdata_d[AWC_CTRL_LJUST_BIT] = ljust_q;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            o_sfr_rdata <= 8'h00;
        else if (i_sfr_rd)
            o_sfr_rdata <= rdata_d;
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            o_conv_enable <= 1'b0;
            o_gain_sel <= AWC_GAIN_UNITY;
            o_pair_diff <= 4'h0;
            o_even_pin_sel <= 4'h0;
            o_odd_pin_sel <= 4'h0;
            o_sar_clk <= 1'b0;
            o_busy <= 1'b0;
            o_result_valid <= 1'b0;
            o_result <= 16'h0000;
            o_window_irq <= 1'b0;
        end
        else
        begin
            o_conv_enable <= enable_q;
            o_gain_sel <= config_q[AWC_CFG_GAIN_LSB +: 3];
            o_pair_diff <= pair_cfg_q[3:0];
            // Even pins 0,2,4,6 and odd pins 1,3,5,7 go to separate mux inputs
            o_even_pin_sel <= {port_sel_q[6], port_sel_q[4], port_sel_q[2], port_sel_q[0]};
            o_odd_pin_sel <= {port_sel_q[7], port_sel_q[5], port_sel_q[3], port_sel_q[1]};
            // Gated by enable so no SAR clock shows in the cycle after a shutdown abort
            o_sar_clk <= (state_q == AWC_ST_CONV) && enable_q && (div_cnt_q <= {1'b0, config_q[7:4]});
            o_busy <= (state_q == AWC_ST_CONV);
            o_result_valid <= win.res_valid;
            o_result <= win.result;
            o_window_irq <= flag_q;
        end
    end

    flag_sticky_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (flag_q && !(i_sfr_wr && hit(AWC_OFF_CTRL))) |=> flag_q)
        else $error("window flag dropped without a clear");
    flag_set_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        win.match |=> flag_q ##1 o_window_irq) else $error("match did not reach flag and request");
    conv_length_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        done_q |-> $past(tick_cnt_q) == AWC_SAR_CLKS_PER_CONV - 5'h01)
        else $error("conversion ended early");
    shutdown_idle_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        !enable_q |=> state_q == AWC_ST_IDLE && !done_q) else $error("converter ran while disabled");
    enable_out_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        o_conv_enable == $past(enable_q)) else $error("enable output lags wrongly");
    pair_reset_a: assert property (@(posedge i_mclk)
        !i_rst_n |=> pair_cfg_q == 8'h00 && config_q[2:0] == AWC_GAIN_UNITY && upper_lo_q == 8'hff)
        else $error("reset values wrong");
    limit_byte_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        (i_sfr_wr && hit(AWC_OFF_UPPER_LO)) |=> upper_lo_q == $past(i_sfr_wdata) && $stable(upper_hi_q))
        else $error("limit byte write disturbed the other byte");
    pair_upper_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
        pair_cfg_q[7:4] == 4'h0) else $error("unused pair bits set");
endmodule

// >>> verification/awc_testbench.sv
/*
 * Self-checking bench for the converter window and input configuration block.
 * Assumes the design files under design/ and one system clock; every input is driven at the falling edge.
 */
`timescale 1ns/1ps
module testbench;
    import awc_pkg::*;

    logic i_mclk, i_rst_n, i_sfr_wr, i_sfr_rd, i_conv_start;
    logic [7:0] i_sfr_page, i_sfr_addr, i_sfr_wdata, o_sfr_rdata;
    logic [3:0] i_chan_sel, o_pair_diff, o_even_pin_sel, o_odd_pin_sel;
    logic [11:0] i_sar_code, code;
    logic [2:0] o_gain_sel;
    logic [15:0] o_result, up, lo, r16;
    logic o_conv_enable, o_sar_clk, o_busy, o_result_valid, o_window_irq;
    logic [31:0] seed, v;
    logic [7:0] pcfg, psel;
    logic [3:0] ch;
    logic flag_m, dif, lj, clr;
    int fails, checked, n, k, seen;
    logic [3:0] chs [6] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8};

    awc_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sfr_page(i_sfr_page), .i_sfr_addr(i_sfr_addr),
        .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .i_sfr_rd(i_sfr_rd), .i_chan_sel(i_chan_sel),
        .i_conv_start(i_conv_start), .i_sar_code(i_sar_code), .o_sfr_rdata(o_sfr_rdata),
        .o_conv_enable(o_conv_enable), .o_gain_sel(o_gain_sel), .o_pair_diff(o_pair_diff),
        .o_even_pin_sel(o_even_pin_sel), .o_odd_pin_sel(o_odd_pin_sel), .o_sar_clk(o_sar_clk),
        .o_busy(o_busy), .o_result_valid(o_result_valid), .o_result(o_result), .o_window_irq(o_window_irq));

    initial
    begin
        i_mclk = 1'b0;
        forever #2 i_mclk = ~i_mclk;
    end

    // ****************************************
    // Helpers and reference model
    // ****************************************
    task automatic chk(input logic [15:0] seen_v, input logic [15:0] exp_v);
        checked++;
        if (seen_v !== exp_v)
        begin
            fails++;
            $display("ERROR at %0t: saw %h expected %h", $time, seen_v, exp_v);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic wr(input logic [7:0] pg, input logic [7:0] a, input logic [7:0] d);
        @(negedge i_mclk);
        i_sfr_page = pg;
        i_sfr_addr = a;
        i_sfr_wdata = d;
        i_sfr_wr = 1'b1;
        @(negedge i_mclk);
        i_sfr_wr = 1'b0;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_mclk);
        i_sfr_page = AWC_PAGE;
        i_sfr_addr = a;
        i_sfr_rd = 1'b1;
        @(negedge i_mclk);
        i_sfr_rd = 1'b0;
        chk(16'(o_sfr_rdata), 16'(e));
    endtask

    function automatic logic [15:0] fmt(input logic [11:0] c, input logic d, input logic l);
        if (l)
            return {c, 4'h0};
        return d ? {{4{c[11]}}, c} : {4'h0, c};
    endfunction

    function automatic int sv(input logic [15:0] x, input logic d);
        return d ? int'($signed(x)) : int'(x);
    endfunction

    // Lower limit above upper selects the inside window, otherwise the outside
    function automatic logic hit(input logic [15:0] r, input logic d);
        if (sv(lo, d) > sv(up, d))
            return sv(r, d) > sv(up, d) && sv(r, d) < sv(lo, d);
        return sv(r, d) < sv(lo, d) || sv(r, d) > sv(up, d);
    endfunction

    // Code is held for the whole conversion since the design samples it late
    task automatic conv(input logic [11:0] c, input logic [3:0] chn, input int lim, output int cyc);
        @(negedge i_mclk);
        i_sar_code = c;
        i_chan_sel = chn;
        i_conv_start = 1'b1;
        @(negedge i_mclk);
        i_conv_start = 1'b0;
        cyc = 1;
        while (o_result_valid !== 1'b1 && cyc < lim)
        begin
            @(negedge i_mclk);
            cyc++;
            if (cyc == 6 && lim > 100)
                chk(16'(o_busy), 16'h1);
        end
    endtask

    // ****************************************
    // Watchdog
    // ****************************************
    initial
    begin
        #100000;
        fails++;
        results();
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        seed = 32'h7b7fabea;
        fails = 0;
        checked = 0;
        flag_m = 1'b0;
        i_rst_n = 1'b0;
        i_sfr_page = 8'h00;
        i_sfr_addr = 8'h00;
        i_sfr_wdata = 8'h00;
        i_sfr_wr = 1'b0;
        i_sfr_rd = 1'b0;
        i_chan_sel = 4'h0;
        i_conv_start = 1'b0;
        i_sar_code = 12'h000;
        repeat (6) @(negedge i_mclk);
        i_rst_n = 1'b1;
        chk(16'(o_pair_diff), 16'h0);
        chk(16'(o_gain_sel), 16'(AWC_GAIN_UNITY));
        chk(16'(o_conv_enable), 16'h0);
        rchk(AWC_OFF_PAIR_CFG, 8'h00);
        rchk(AWC_OFF_UPPER_LO, 8'hff);
        rchk(AWC_OFF_UPPER_HI, AWC_RST_UPPER_HI);
        rchk(AWC_OFF_LOWER_LO, AWC_RST_LOWER_LO);
        rchk(AWC_OFF_CONFIG, AWC_RST_CONFIG);
        rchk(AWC_OFF_CTRL, 8'h00);
        rchk(8'hc0, 8'h00);
        wr(8'h01, AWC_OFF_UPPER_LO, 8'h00);
        rchk(AWC_OFF_UPPER_LO, 8'hff);
        wr(AWC_PAGE, AWC_OFF_UPPER_LO, 8'h5a);
        rchk(AWC_OFF_UPPER_LO, 8'h5a);
        rchk(AWC_OFF_UPPER_HI, AWC_RST_UPPER_HI);
        wr(AWC_PAGE, AWC_OFF_PAIR_CFG, 8'hff);
        rchk(AWC_OFF_PAIR_CFG, 8'h0f);
        chk(16'(o_pair_diff), 16'hf);
        for (k = 0; k < 8; k++)
        begin
            wr(AWC_PAGE, AWC_OFF_CONFIG, 8'(k));
            @(negedge i_mclk);
            chk(16'(o_gain_sel), 16'(k));
        end
        for (k = 0; k < 4; k++)
        begin
            v = rnd();
            // One even and one odd pin at a time, so no two sources share a mux input
            psel = (8'h01 << {v[1:0], 1'b0}) | (8'h02 << {v[3:2], 1'b0});
            wr(AWC_PAGE, AWC_OFF_PORT_SEL, psel);
            @(negedge i_mclk);
            chk(16'(o_even_pin_sel), 16'({psel[6], psel[4], psel[2], psel[0]}));
            chk(16'(o_odd_pin_sel), 16'({psel[7], psel[5], psel[3], psel[1]}));
        end
        // Divider of one keeps the run short; field software slows the SAR clock to its limit
        wr(AWC_PAGE, AWC_OFF_CONFIG, 8'h08);
        conv(12'h123, 4'h0, 60, n);
        chk(16'(o_result_valid), 16'h0);
        wr(AWC_PAGE, AWC_OFF_CTRL, 8'h80);
        @(negedge i_mclk);
        chk(16'(o_conv_enable), 16'h1);
        // Dropping enable mid-conversion must abandon it without a result
        @(negedge i_mclk);
        i_conv_start = 1'b1;
        @(negedge i_mclk);
        i_conv_start = 1'b0;
        repeat (8) @(negedge i_mclk);
        wr(AWC_PAGE, AWC_OFF_CTRL, 8'h00);
        seen = 0;
        repeat (60)
        begin
            @(negedge i_mclk);
            seen += (o_result_valid === 1'b1 || o_sar_clk === 1'b1) ? 1 : 0;
        end
        chk(16'(seen), 16'h0);
        chk(16'(o_busy), 16'h0);
        for (k = 0; k < 48; k++)
        begin
            v = rnd();
            pcfg = {4'h0, v[3:0]};
            lj = v[4];
            clr = (k % 4 == 0);
            ch = chs[v[31:8] % 6];
            dif = (ch == 4'h0 && pcfg[0]) || (ch == 4'h2 && pcfg[1]) || (ch == 4'h4 && pcfg[2])
                || (ch == 4'h6 && pcfg[3]);
            v = rnd();
            up = fmt(v[11:0], dif, lj);
            lo = fmt(v[27:16], dif, lj);
            wr(AWC_PAGE, AWC_OFF_UPPER_HI, up[15:8]);
            wr(AWC_PAGE, AWC_OFF_UPPER_LO, up[7:0]);
            wr(AWC_PAGE, AWC_OFF_LOWER_HI, lo[15:8]);
            wr(AWC_PAGE, AWC_OFF_LOWER_LO, lo[7:0]);
            wr(AWC_PAGE, AWC_OFF_PAIR_CFG, pcfg);
            wr(AWC_PAGE, AWC_OFF_CTRL, {6'h20, ~clr, lj});
            if (clr)
                flag_m = 1'b0;
            v = rnd();
            code = v[11:0];
            conv(code, ch, 2000, n);
            r16 = fmt(code, dif, lj);
            flag_m = flag_m | hit(r16, dif);
            chk(16'(o_result_valid), 16'h1);
            chk(o_result, r16);
            // The request follows the flag one cycle later
            @(negedge i_mclk);
            chk(16'(o_window_irq), 16'(flag_m));
            chk(16'(n >= 32), 16'h1);
            rchk(AWC_OFF_CTRL, {6'h20, flag_m, lj});
        end
        results();
    end
endmodule
